// >>> inc/pic_defs.vh
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
// ****************************************
// Configuration
// ****************************************
`define PIC_IC_LOW      32'h0010_0000
`define PIC_IC_HIGH     32'h0010_ffff
`define PIC_DC_LOW      32'h0020_0000
`define PIC_DC_HIGH     32'h0020_ffff
`define PIC_BUS_WIDTH   32
`define PIC_WRITEBACK   1'b1
`define PIC_MMU_LEVEL   2'h0
`define PIC_AREA_OPT    1'b0
`define PIC_PARITY      1'b1
`define PIC_STREAMS     1'b1
`define PIC_VICTIMS     2
`define PIC_INV_ALLOW   1'b1
// ****************************************
// Register map
// ****************************************
`define PIC_REG_CTRL    4'h0
`define PIC_REG_STATUS  4'h4
`define PIC_REG_ICINV   4'h8
`define PIC_CTRL_IC     0
`define PIC_CTRL_DC     1
`define PIC_CTRL_RESET  2'h0
`define PIC_BURST_LEN   2'h3
`endif

// >>> hdl/pic_cache.v
`include "pic_defs.vh"
module pic_cache (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Register port
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata_q,
    // Fetch side
    input  wire        iReq,
    input  wire [31:0] iAddr,
    output reg         iAck_q,
    output reg  [31:0] iData_q,
    output reg         iPassive_q,
    input  wire        icInvReq,
    input  wire [31:0] icInvAddr,
    // Load/store side
    input  wire        dReq,
    input  wire        dWe,
    input  wire [31:0] dAddr,
    input  wire [31:0] dWdata,
    input  wire [3:0]  dBe,
    output reg         dAck_q,
    output reg  [31:0] dData_q,
    output reg         dPassive_q,
    input  wire        virtMode,
    input  wire        pageWt,
    // Memory link
    output reg         memValid_q,
    input  wire        memReady,
    output reg         memWe_q,
    output reg  [31:0] memAddr_q,
    output reg  [31:0] memWdata_q,
    output reg  [3:0]  memBe_q,
    output reg  [1:0]  memLen_q,
    input  wire        memRvalid,
    input  wire [`PIC_BUS_WIDTH-1:0] memRdata
);
// ****************************************
// States and options
// ****************************************
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_IRD  = 6'h02;
localparam [5:0] ST_PRE  = 6'h04;
localparam [5:0] ST_WB   = 6'h08;
localparam [5:0] ST_DRD  = 6'h10;
localparam [5:0] ST_WT   = 6'h20;
localparam USE_SB = `PIC_STREAMS && !`PIC_AREA_OPT;
localparam USE_VC = (`PIC_VICTIMS > 0) && !`PIC_AREA_OPT;

function inRange;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
        inRange = (a >= lo) && (a <= hi);
    end
endfunction

function [31:0] mergeBe;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer b;
    begin
        mergeBe = old;
        for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) mergeBe[b*8 +: 8] = nw[b*8 +: 8];
        end
    end
endfunction

// ****************************************
// Storage
// ****************************************
reg [23:0] iTag [0:15];
reg [31:0] iMem [0:63];
reg        iDpar [0:63];
reg [3:0]  iWv [0:15];
reg [15:0] iLv_q;
reg [15:0] iTpar;
reg [23:0] dTag [0:15];
reg [31:0] dMem [0:63];
reg        dDpar [0:63];
reg [3:0]  dWv [0:15];
reg [15:0] dLv_q;
reg [15:0] dDirty_q;
reg [15:0] dTpar;
reg [27:0] vLine [0:1];
reg [31:0] vData [0:7];
reg [1:0]  vVal_q;
reg        vPtr_q;
reg [27:0] sLine [0:1];
reg [31:0] sData [0:7];
reg [1:0]  sVal_q;
reg [27:0] pNext_q;
reg        pAct_q;
reg [31:0] fBuf [0:2];
reg [1:0]  bCnt_q;
reg [2:0]  wbW_q;
reg [5:0]  st_q;
reg [1:0]  ctrl_q;

// ****************************************
// Instruction lookup
// ****************************************
wire [3:0]  iIx  = iAddr[7:4];
wire [5:0]  iWi  = iAddr[7:2];
wire        iCach = ctrl_q[`PIC_CTRL_IC] &&
                    inRange(iAddr, `PIC_IC_LOW, `PIC_IC_HIGH);
wire        iParOk = !`PIC_PARITY ||
                     ((^iTag[iIx] == iTpar[iIx]) &&
                      (^iMem[iWi] == iDpar[iWi]));
wire        iHit = iLv_q[iIx] && iWv[iIx][iAddr[3:2]] &&
                   iTag[iIx] == iAddr[31:8] && iParOk;
wire [1:0]  vHit;
wire [1:0]  sHit;
genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : gMatch
        assign vHit[g] = USE_VC && vVal_q[g] && vLine[g] == iAddr[31:4];
        assign sHit[g] = USE_SB && sVal_q[g] && sLine[g] == iAddr[31:4];
    end
endgenerate
wire        vi = vHit[1];
wire        si = sHit[1];
wire        iLook = iReq && iCach && !iAck_q && st_q != ST_IRD;
wire        iUseV = iLook && !iHit && |vHit;
wire        iUseS = iLook && !iHit && !(|vHit) && |sHit;
wire        iMiss = iLook && !iHit && !(|vHit) && !(|sHit);
wire        iFillEnd = st_q == ST_IRD && memRvalid && bCnt_q == 2'h3;
wire        iInst = iUseV || iUseS || iFillEnd;
wire        sFree = !(&sVal_q);
wire        pWant = USE_SB && pAct_q && sFree && ctrl_q[`PIC_CTRL_IC] &&
                    inRange({pNext_q, 4'h0}, `PIC_IC_LOW, `PIC_IC_HIGH);

// ****************************************
// Data lookup
// ****************************************
wire [3:0]  dIx  = dAddr[7:4];
wire [5:0]  dWi  = dAddr[7:2];
wire        wbEff = `PIC_WRITEBACK &&
                    (`PIC_MMU_LEVEL <= 2'h1 || `PIC_AREA_OPT ||
                     !virtMode || !pageWt);
wire        dCach = ctrl_q[`PIC_CTRL_DC] &&
                    inRange(dAddr, `PIC_DC_LOW, `PIC_DC_HIGH);
wire        dParOk = !`PIC_PARITY || wbEff ||
                     ((^dTag[dIx] == dTpar[dIx]) &&
                      (^dMem[dWi] == dDpar[dWi]));
wire        dHit = dLv_q[dIx] && dWv[dIx][dAddr[3:2]] &&
                   dTag[dIx] == dAddr[31:8] && dParOk;
wire        dLook = dReq && dCach && !dAck_q && st_q == ST_IDLE;
wire        dVicDirty = wbEff && dLv_q[dIx] && dDirty_q[dIx] &&
                        dTag[dIx] != dAddr[31:8];
wire        dFull = (dWv[dIx] == 4'hf);
wire [31:0] dLineBase = {dAddr[31:4], 4'h0};

integer k;
// ****************************************
// Sequencer and storage update
// ****************************************
always @(posedge clk or posedge rst) begin
    if (rst) begin
        st_q        <= ST_IDLE;
        ctrl_q      <= `PIC_CTRL_RESET;
        iLv_q       <= 16'h0;
        dLv_q       <= 16'h0;
        dDirty_q    <= 16'h0;
        vVal_q      <= 2'h0;
        vPtr_q      <= 1'b0;
        sVal_q      <= 2'h0;
        pNext_q     <= 28'h0;
        pAct_q      <= 1'b0;
        bCnt_q      <= 2'h0;
        wbW_q       <= 3'h0;
        regRdata_q  <= 32'h0;
        iAck_q      <= 1'b0;
        iData_q     <= 32'h0;
        iPassive_q  <= 1'b0;
        dAck_q      <= 1'b0;
        dData_q     <= 32'h0;
        dPassive_q  <= 1'b0;
        memValid_q  <= 1'b0;
        memWe_q     <= 1'b0;
        memAddr_q   <= 32'h0;
        memWdata_q  <= 32'h0;
        memBe_q     <= 4'h0;
        memLen_q    <= 2'h0;
    end else begin
        iAck_q     <= 1'b0;
        dAck_q     <= 1'b0;
        iPassive_q <= iReq && !iCach;
        dPassive_q <= dReq && !dCach;
        regRdata_q <= 32'h0;
        if (regRd) begin
            case (regAddr)
                `PIC_REG_CTRL:   regRdata_q <= {30'h0, ctrl_q};
                `PIC_REG_STATUS: regRdata_q <= {22'h0, pAct_q, vVal_q,
                                                sVal_q, st_q[4:0]};
                default:         regRdata_q <= 32'h0;
            endcase
        end
        if (regWr && regAddr == `PIC_REG_CTRL) ctrl_q <= regWdata[1:0];
        // Fetch hit
        if (iLook && iHit) begin
            iAck_q  <= 1'b1;
            iData_q <= iMem[iWi];
        end
        // Line install with eviction to victim store
        if (iInst) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (iUseV) begin
                    iMem[{iIx, k[1:0]}]  <= vData[{vi, k[1:0]}];
                    iDpar[{iIx, k[1:0]}] <= ^vData[{vi, k[1:0]}];
                end else if (iUseS) begin
                    iMem[{iIx, k[1:0]}]  <= sData[{si, k[1:0]}];
                    iDpar[{iIx, k[1:0]}] <= ^sData[{si, k[1:0]}];
                end else if (k == 3) begin
                    iMem[{iIx, 2'h3}]  <= memRdata;
                    iDpar[{iIx, 2'h3}] <= ^memRdata;
                end else begin
                    iMem[{iIx, k[1:0]}]  <= fBuf[k];
                    iDpar[{iIx, k[1:0]}] <= ^fBuf[k];
                end
            end
            iTag[iIx]     <= iAddr[31:8];
            iTpar[iIx]    <= ^iAddr[31:8];
            iWv[iIx]      <= 4'hf;
            iLv_q[iIx]    <= 1'b1;
            if (iUseV) vVal_q[vi] <= 1'b0;
            if (iUseS) sVal_q[si] <= 1'b0;
            if (USE_VC && iLv_q[iIx]) begin
                vLine[iUseV ? vi : vPtr_q] <= {iTag[iIx], iIx};
                for (k = 0; k < 4; k = k + 1) begin
                    vData[{(iUseV ? vi : vPtr_q), k[1:0]}] <=
                        iMem[{iIx, k[1:0]}];
                end
                vVal_q[iUseV ? vi : vPtr_q] <= 1'b1;
                if (!iUseV) vPtr_q <= ~vPtr_q;
            end
        end
        // Data hit paths and full-word store miss allocation, no memory needed
        if (dLook) begin
            if (!dWe && dHit) begin
                dAck_q  <= 1'b1;
                dData_q <= dMem[dWi];
            end else if (dWe && wbEff && dHit) begin
                dMem[dWi]      <= mergeBe(dMem[dWi], dWdata, dBe);
                dDirty_q[dIx]  <= 1'b1;
                dAck_q         <= 1'b1;
            end else if (dWe && wbEff && !dVicDirty && dBe == 4'hf) begin
                dMem[dWi]     <= dWdata;
                dTag[dIx]     <= dAddr[31:8];
                dTpar[dIx]    <= ^dAddr[31:8];
                dWv[dIx]      <= (dTag[dIx] == dAddr[31:8] && dLv_q[dIx]) ?
                                 (dWv[dIx] | (4'h1 << dAddr[3:2])) :
                                 (4'h1 << dAddr[3:2]);
                dLv_q[dIx]    <= 1'b1;
                dDirty_q[dIx] <= 1'b1;
                dAck_q        <= 1'b1;
            end
        end
        case (st_q)
            ST_IDLE: begin
                if (dLook && dVicDirty && !(dWe && dHit)) begin
                    wbW_q <= 3'h0;
                    st_q  <= ST_WB;
                end else if (dLook && dWe && !wbEff) begin
                    memValid_q <= 1'b1;
                    memWe_q    <= 1'b1;
                    memAddr_q  <= dAddr;
                    memWdata_q <= dWdata;
                    memBe_q    <= dBe;
                    memLen_q   <= 2'h0;
                    st_q       <= ST_WT;
                end else if (dLook && !dHit &&
                             (!dWe || dBe != 4'hf)) begin
                    memValid_q <= 1'b1;
                    memWe_q    <= 1'b0;
                    memAddr_q  <= dLineBase;
                    memBe_q    <= 4'hf;
                    memLen_q   <= `PIC_BURST_LEN;
                    bCnt_q     <= 2'h0;
                    st_q       <= ST_DRD;
                end else if (iMiss) begin
                    memValid_q <= 1'b1;
                    memWe_q    <= 1'b0;
                    memAddr_q  <= {iAddr[31:4], 4'h0};
                    memBe_q    <= 4'hf;
                    memLen_q   <= `PIC_BURST_LEN;
                    bCnt_q     <= 2'h0;
                    sVal_q     <= 2'h0;
                    pAct_q     <= 1'b0;
                    st_q       <= ST_IRD;
                end else if (pWant && !iInst) begin
                    memValid_q <= 1'b1;
                    memWe_q    <= 1'b0;
                    memAddr_q  <= {pNext_q, 4'h0};
                    memBe_q    <= 4'hf;
                    memLen_q   <= `PIC_BURST_LEN;
                    bCnt_q     <= 2'h0;
                    st_q       <= ST_PRE;
                end
            end
            ST_IRD, ST_PRE, ST_DRD: begin
                if (memValid_q && memReady) memValid_q <= 1'b0;
                if (memRvalid) begin
                    bCnt_q <= bCnt_q + 2'h1;
                    if (st_q == ST_IRD && bCnt_q != 2'h3) fBuf[bCnt_q] <= memRdata;
                    if (st_q == ST_PRE) sData[{sVal_q[0], bCnt_q}] <= memRdata;
                    if (st_q == ST_DRD) begin
                        dMem[{dIx, bCnt_q}]  <= memRdata;
                        dDpar[{dIx, bCnt_q}] <= ^memRdata;
                    end
                    if (bCnt_q == 2'h3) begin
                        st_q <= ST_IDLE;
                        if (st_q == ST_IRD) begin
                            pNext_q <= iAddr[31:4] + 28'h1;
                            pAct_q  <= USE_SB;
                            iAck_q  <= 1'b1;
                            iData_q <= (iAddr[3:2] == 2'h3) ? memRdata :
                                       fBuf[iAddr[3:2]];
                        end
                        if (st_q == ST_PRE) begin
                            sLine[sVal_q[0]]  <= pNext_q;
                            sVal_q[sVal_q[0]] <= 1'b1;
                            pNext_q            <= pNext_q + 28'h1;
                        end
                        if (st_q == ST_DRD) begin
                            dTag[dIx]     <= dAddr[31:8];
                            dTpar[dIx]    <= ^dAddr[31:8];
                            dWv[dIx]      <= 4'hf;
                            dLv_q[dIx]    <= 1'b1;
                            dDirty_q[dIx] <= 1'b0;
                        end
                    end
                end
            end
            ST_WB: begin
                if (!memValid_q || memReady) begin
                    if (wbW_q[2]) begin
                        memValid_q    <= 1'b0;
                        dDirty_q[dIx] <= 1'b0;
                        st_q          <= ST_IDLE;
                    end else begin
                        memValid_q <= dWv[dIx][wbW_q[1:0]];
                        memWe_q    <= 1'b1;
                        memAddr_q  <= {dTag[dIx], dIx, wbW_q[1:0], 2'h0};
                        memWdata_q <= dMem[{dIx, wbW_q[1:0]}];
                        memBe_q    <= 4'hf;
                        memLen_q   <= dFull ? `PIC_BURST_LEN : 2'h0;
                        wbW_q      <= wbW_q + 3'h1;
                    end
                end
            end
            ST_WT: begin
                if (memReady) begin
                    memValid_q <= 1'b0;
                    dAck_q     <= 1'b1;
                    st_q       <= ST_IDLE;
                    if (dHit) begin
                        dMem[dWi]  <= mergeBe(dMem[dWi], dWdata, dBe);
                        dDpar[dWi] <= ^mergeBe(dMem[dWi], dWdata, dBe);
                    end
                end
            end
            default: st_q <= ST_IDLE;
        endcase
        // Line invalidation wins over a fill in the same cycle
        if (`PIC_INV_ALLOW && icInvReq) begin
            iLv_q[icInvAddr[7:4]] <= 1'b0;
            iWv[icInvAddr[7:4]]   <= 4'h0;
        end
        if (regWr && regAddr == `PIC_REG_ICINV) begin
            iLv_q[regWdata[7:4]] <= 1'b0;
            iWv[regWdata[7:4]]   <= 4'h0;
        end
    end
end

endmodule // pic_cache

// >>> bench/pic_cache_sva.sv
`include "pic_defs.vh"
module pic_cache_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Watched ports
    input wire logic        regRd,
    input wire logic [31:0] regRdata_q,
    input wire logic        iReq,
    input wire logic [31:0] iAddr,
    input wire logic        iAck_q,
    input wire logic        iPassive_q,
    input wire logic        dReq,
    input wire logic [31:0] dAddr,
    input wire logic        dAck_q,
    input wire logic        dPassive_q,
    input wire logic        memValid_q,
    input wire logic        memReady,
    input wire logic        memWe_q,
    input wire logic [31:0] memAddr_q,
    input wire logic [1:0]  memLen_q
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic iIn = iAddr >= `PIC_IC_LOW && iAddr <= `PIC_IC_HIGH;
    wire logic dIn = dAddr >= `PIC_DC_LOW && dAddr <= `PIC_DC_HIGH;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ********
    // Sequences
    // ********
    sequence s_rdCmd;
        memValid_q && memReady && !memWe_q;
    endsequence
    sequence s_burstStep;
        memValid_q && memReady && memWe_q && memLen_q == `PIC_BURST_LEN
            && memAddr_q[3:2] != 2'h3;
    endsequence
    property p_iPassive;
        iReq && !iIn |=> iPassive_q && !iAck_q;
    endproperty
    property p_iRange;
        iAck_q |-> $past(iReq) && $past(iIn);
    endproperty
    property p_dPassive;
        dReq && !dIn |=> dPassive_q && !dAck_q;
    endproperty
    property p_rdLine;
        s_rdCmd |-> memLen_q == `PIC_BURST_LEN;
    endproperty
    property p_fillWait;
        s_rdCmd |=> !dAck_q [*4];
    endproperty
    property p_burst;
        s_burstStep |=> memValid_q && memWe_q
            && memAddr_q == $past(memAddr_q) + 32'h4;
    endproperty
    property p_hold;
        memValid_q && !memReady |=> memValid_q && $stable(memAddr_q)
            && $stable(memLen_q) && $stable(memWe_q);
    endproperty
    property p_ackPulse;
        iAck_q |=> !iAck_q;
    endproperty
    property p_regIdle;
        !regRd |=> regRdata_q == 32'h0;
    endproperty
    a_iPassive: assert property (p_iPassive)
        else $error("fetch outside range not left passive");
    a_iRange: assert property (p_iRange)
        else $error("fetch ack without cacheable request");
    a_dPassive: assert property (p_dPassive)
        else $error("data access outside range not left passive");
    a_rdLine: assert property (p_rdLine)
        else $error("read command not a whole line");
    a_fillWait: assert property (p_fillWait)
        else $error("data ack before line returned");
    a_burst: assert property (p_burst)
        else $error("burst writeback not back to back");
    a_hold: assert property (p_hold)
        else $error("memory command changed before accept");
    a_ackPulse: assert property (p_ackPulse)
        else $error("fetch ack longer than one cycle");
    a_regIdle: assert property (p_regIdle)
        else $error("read data not zero outside read slot");
endmodule // pic_cache_chk
bind pic_cache pic_cache_chk pic_cache_chk_i (
    .clk, .rst, .regRd, .regRdata_q, .iReq, .iAddr, .iAck_q, .iPassive_q,
    .dReq, .dAddr, .dAck_q, .dPassive_q, .memValid_q, .memReady,
    .memWe_q, .memAddr_q, .memLen_q
);

// >>> bench/pic_mem_model.sv
module pic_mem_model (
    // Clock, reset and slow-response select
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        slow,
    // Memory link
    input wire logic        memValid_q,
    output logic            memReady,
    input wire logic        memWe_q,
    input wire logic [31:0] memAddr_q,
    input wire logic [31:0] memWdata_q,
    input wire logic [3:0]  memBe_q,
    output logic            memRvalid,
    output logic [31:0]     memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] store [logic [29:0]];
    logic [2:0]  waitCnt;
    logic [2:0]  beatsLeft;
    logic [31:0] lineBase;
    logic [31:0] w;
    function automatic logic [31:0] peek(input logic [31:0] a);
        return store.exists(a[31:2]) ? store[a[31:2]] : a ^ 32'ha5a5_0000;
    endfunction
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            memReady <= 1'b0;
            memRvalid <= 1'b0;
            memRdata <= 32'h0;
            waitCnt <= 3'h0;
            beatsLeft <= 3'h0;
            lineBase <= 32'h0;
        end else begin
            memReady <= 1'b0;
            memRvalid <= beatsLeft != 3'h0;
            memRdata <= ~memRdata;
            if (memValid_q && !memReady && beatsLeft == 3'h0) begin
                waitCnt <= waitCnt + 3'h1;
                if (waitCnt >= (slow ? 3'h3 : 3'h0)) begin
                    memReady <= 1'b1;
                    waitCnt <= 3'h0;
                end
            end
            if (memValid_q && memReady && memWe_q) begin
                w = peek(memAddr_q);
                for (int b = 0; b < 4; b++)
                    if (memBe_q[b]) w[8*b +: 8] = memWdata_q[8*b +: 8];
                store[memAddr_q[31:2]] = w;
            end else if (memValid_q && memReady) begin
                beatsLeft <= 3'h4;
                lineBase <= {memAddr_q[31:4], 4'h0};
            end
            if (beatsLeft != 3'h0) begin
                memRdata <= peek(lineBase + {27'h0, 3'h4 - beatsLeft, 2'h0});
                beatsLeft <= beatsLeft - 3'h1;
            end
        end
    end
endmodule // pic_mem_model

// >>> bench/pic_cache_test.sv
module pic_cache_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, regWr, regRd, iReq, iAck_q, iPassive_q;
    logic        icInvReq, dReq, dWe, dAck_q, dPassive_q, slow;
    logic        virtMode, pageWt, memValid_q, memReady, memWe_q, memRvalid;
    logic [1:0]  memLen_q, wrLen;
    logic [3:0]  regAddr, dBe, memBe_q;
    logic [31:0] regWdata, regRdata_q, iAddr, iData_q, icInvAddr, v;
    logic [31:0] dAddr, dWdata, dData_q, memAddr_q, memWdata_q, memRdata;
    logic [31:0] wrAddr, rdAddr;
    int          err_total, checked, nRd, nWr, n, r0, w0;
    bit          ps;
    pic_cache pic_cache_i (
        .clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata_q,
        .iReq, .iAddr, .iAck_q, .iData_q, .iPassive_q, .icInvReq,
        .icInvAddr, .dReq, .dWe, .dAddr, .dWdata, .dBe, .dAck_q, .dData_q,
        .dPassive_q, .virtMode, .pageWt, .memValid_q, .memReady, .memWe_q,
        .memAddr_q, .memWdata_q, .memBe_q, .memLen_q, .memRvalid, .memRdata
    );
    pic_mem_model pic_mem_model_i (
        .clk, .rst, .slow, .memValid_q, .memReady, .memWe_q, .memAddr_q,
        .memWdata_q, .memBe_q, .memRvalid, .memRdata
    );
    always #5 clk = ~clk;
    always @(negedge clk)
        if (memValid_q && memReady) begin
            if (memWe_q) begin
                nWr++;
                wrLen = memLen_q;
                wrAddr = memAddr_q;
            end else begin
                nRd++;
                rdAddr = memAddr_q;
            end
        end
    // ********
    // Helpers
    // ********
    function automatic logic [31:0] pat(input logic [31:0] a);
        return a ^ 32'ha5a5_0000;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        d = regRdata_q;
    endtask
    task automatic acc(input bit dat, we, input logic [31:0] a, wd,
                       input logic [3:0] be);
        dReq <= dat;
        dWe <= we;
        dAddr <= a;
        dWdata <= wd;
        dBe <= be;
        iReq <= !dat;
        iAddr <= a;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((dat ? dAck_q : iAck_q) !== 1'b1 && n < 100);
        v = dat ? dData_q : iData_q;
        ps = (dat ? dPassive_q : iPassive_q) === 1'b1 && n == 100;
        iReq <= 1'b0;
        dReq <= 1'b0;
        @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_off;
        acc(0, 0, 32'h0010_0000, 0, 0);
        chk("fetch off passive", 1, ps);
        acc(1, 0, 32'h0020_0000, 0, 0);
        chk("load off passive", 1, ps);
        $display("test off done");
    endtask
    task automatic t_regs;
        rd(4'h0, v);
        chk("ctrl reset", 0, v);
        wr(4'hc, 32'hff);
        rd(4'hc, v);
        chk("unmapped read", 0, v);
        wr(4'h0, 32'h3);
        rd(4'h0, v);
        chk("ctrl on", 3, v);
        $display("test regs done");
    endtask
    task automatic t_range;
        acc(0, 0, 32'h0000_1000, 0, 0);
        chk("fetch low passive", 1, ps);
        acc(0, 0, 32'h0011_0000, 0, 0);
        chk("fetch high passive", 1, ps);
        acc(1, 1, 32'h001f_fffc, 1, 4'hf);
        chk("store low passive", 1, ps);
        acc(1, 0, 32'h0021_0000, 0, 0);
        chk("load high passive", 1, ps);
        $display("test range done");
    endtask
    task automatic t_ifetch;
        r0 = nRd;
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("miss word", pat(32'h0010_0004), v);
        chk("miss waits", 1, n > 5);
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("hit latency", 2, n);
        repeat (60) @(posedge clk);
        chk("prefetch lines", r0 + 3, nRd);
        acc(0, 0, 32'h0010_0014, 0, 0);
        chk("stream word", pat(32'h0010_0014), v);
        chk("stream fast", 1, n <= 3 && nRd == r0 + 4 &&
            rdAddr == 32'h0010_0030);
        $display("test ifetch done");
    endtask
    task automatic t_victim;
        acc(0, 0, 32'h0010_0100, 0, 0);
        chk("conflict word", pat(32'h0010_0100), v);
        repeat (60) @(posedge clk);
        r0 = nRd;
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("victim word", pat(32'h0010_0004), v);
        chk("victim fast", 1, n <= 3 && nRd == r0);
        $display("test victim done");
    endtask
    task automatic t_inv;
        icInvAddr <= 32'h0010_0000;
        icInvReq <= 1'b1;
        @(posedge clk);
        icInvReq <= 1'b0;
        @(posedge clk);
        r0 = nRd;
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("refetch", 1, nRd > r0 && n > 5);
        wr(4'h0, 32'h2);
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("disabled passive", 1, ps);
        wr(4'h0, 32'h3);
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("kept line", 2, n);
        wr(4'h8, 32'h0);
        acc(0, 0, 32'h0010_0004, 0, 0);
        chk("debug invalidate", 1, n > 5);
        $display("test inv done");
    endtask
    task automatic t_dload;
        repeat (60) @(posedge clk);
        acc(1, 0, 32'h0020_0040, 0, 0);
        chk("load miss", pat(32'h0020_0040), v);
        chk("load stall", 1, n > 5);
        acc(1, 0, 32'h0020_0040, 0, 0);
        chk("load hit", 2, n);
        $display("test dload done");
    endtask
    task automatic t_wb;
        slow <= 1'b1;
        w0 = nWr;
        acc(1, 1, 32'h0020_0040, 32'h1234_5678, 4'hf);
        chk("store hit", 1, n == 2 && nWr == w0);
        acc(1, 0, 32'h0020_0140, 0, 0);
        chk("evict load", pat(32'h0020_0140), v);
        chk("burst len", 3, wrLen);
        acc(1, 0, 32'h0020_0040, 0, 0);
        chk("written back", 32'h1234_5678, v);
        chk("clean after", w0 + 4, nWr);
        slow <= 1'b0;
        $display("test wb done");
    endtask
    task automatic t_part;
        r0 = nRd;
        acc(1, 1, 32'h0020_0280, 32'hab, 4'h1);
        chk("byte miss fetch", 1, nRd > r0);
        acc(1, 0, 32'h0020_0280, 0, 0);
        chk("byte merge", pat(32'h0020_0280) & 32'hffff_ff00 | 32'hab, v);
        r0 = nRd;
        acc(1, 1, 32'h0020_0390, 32'hcafe_0001, 4'hf);
        chk("word miss", 1, n == 2 && nRd == r0);
        w0 = nWr;
        acc(1, 0, 32'h0020_0490, 0, 0);
        chk("single write", 1, wrLen == 0 && nWr == w0 + 1);
        chk("single addr", 32'h0020_0390, wrAddr);
        acc(1, 0, 32'h0020_0390, 0, 0);
        chk("word kept", 32'hcafe_0001, v);
        $display("test part done");
    endtask
    initial begin
        {clk, regWr, regRd, iReq, icInvReq, dReq, dWe, slow} = '0;
        {virtMode, pageWt, regAddr, dBe} = '0;
        {regWdata, iAddr, icInvAddr, dAddr, dWdata} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_off();
        t_regs();
        t_range();
        t_ifetch();
        t_victim();
        t_inv();
        t_dload();
        t_wb();
        t_part();
        report_and_stop();
    end
    initial begin
        #300000;
        err_total++;
        report_and_stop();
    end
endmodule // pic_cache_test
